// ### core/irtp_timer_pair.sv
/*
 * 8-bit and 16-bit down-counter pair for IR pulse generation and
 * demodulation capture, with ping-pong alternation and an Avalon-MM
 * register slave. Assumes pins and bus are synchronous to clk.
 */
`timescale 1ns/100ps
module irtp_timer_pair (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Avalon-MM slave
    input  wire irtp_pkg::irtp_avs_req_t avsReq,
    output logic [31:0]                 avsReadData,
    output logic                        avsWaitRequest,
    // Pins and system events
    input  wire logic                   portOutBit,
    input  wire logic                   demodIn,
    input  wire logic                   stopRecover,
    output logic                        port3Bit4Pin,
    output logic                        eightBitCounterOutput,
    output logic                        sixteenBitCounterOutput,
    output logic                        irq
);
    import irtp_pkg::*;

    logic [1:0]  rstSync_r;
    logic        rstn;
    logic        waitReq_r;
    logic [31:0] readData_r;
    logic [7:0]  rdMux;
    logic        wr;
    logic [7:0]  wd;
    logic [2:0]  pre_r;
    // Control bits
    logic        pinSel_r, toIe8_r, capIe8_r, flag8_r, single8_r, en8_r;
    logic [1:0]  clk8_r;
    logic        toIe16_r, capIe16_r, flag16_r, single16_r, en16_r, armed_r;
    logic [1:0]  clk16_r;
    logic [6:0]  shared_r;
    logic [7:0]  hold8H_r, hold8L_r, cap8_r;
    logic [15:0] hold16_r, cap16_r;
    logic [7:0]  cnt8_r;
    logic [15:0] cnt16_r;
    logic        out8_r, out16_r, pin_r, demodPrev_r;
    logic [3:0]  irqStat_r, irqMask_r;
    logic        irq_r;
    // Decoded conditions
    logic        tick8, tick16, demod, pingPong, edgeSeen;
    logic        term8, to16, take16, cap16Ev, cap8Ev;
    logic        wrCtl8, wrCtl16;
    logic [3:0]  irqSet;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstn = rstSync_r[1];

    // Divider tick per clock select code
    function automatic logic tickOf(input logic [1:0] sel, input logic [2:0] pre);
        case (sel)
            2'h0:    tickOf = 1'b1;
            2'h1:    tickOf = pre[0];
            2'h2:    tickOf = &pre[1:0];
            default: tickOf = &pre;
        endcase
    endfunction : tickOf

    // Shared prescaler, free running so both counters stay phase aligned
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pre_r <= 3'h0;
        else
            pre_r <= pre_r + 3'h1;
    end

    assign tick8    = tickOf(clk8_r, pre_r);
    assign tick16   = tickOf(clk16_r, pre_r);
    assign demod    = shared_r[B_DEMOD];
    assign pingPong = shared_r[B_MODEHI:B_MODELO] == MODE_PINGPONG;
    assign wr       = avsReq.write && !waitReq_r && avsReq.byteenable[0];
    assign wd       = avsReq.writedata[7:0];
    assign wrCtl8   = wr && avsReq.address == OFF_CTL8;
    assign wrCtl16  = wr && avsReq.address == OFF_CTL16;

    // Input edge of the selected polarity
    always_comb
    begin
        case (shared_r[B_EDGEHI:B_EDGELO])
            EDGE_RISE: edgeSeen = demodIn && !demodPrev_r;
            EDGE_FALL: edgeSeen = !demodIn && demodPrev_r;
            EDGE_BOTH: edgeSeen = demodIn != demodPrev_r;
            default:   edgeSeen = 1'b0;
        endcase
    end

    // Events; 16-bit edge take is gated once the single pass is used
    assign term8   = en8_r && tick8 && cnt8_r == RST_BYTE;
    assign take16  = en16_r && demod && edgeSeen && (!single16_r || armed_r);
    assign to16    = en16_r && tick16 && cnt16_r == RST_WORD && !take16;
    assign cap16Ev = take16 || (en16_r && demod && single16_r && term8);
    assign cap8Ev  = en8_r && demod && edgeSeen;
    assign irqSet  = {cap16Ev && capIe16_r, to16 && toIe16_r,
                      cap8Ev && capIe8_r, term8 && toIe8_r};

    // Avalon handshake: one wait cycle, then a single ready cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            waitReq_r  <= 1'b1;
            readData_r <= 32'h0000_0000;
        end
        else
        begin
            waitReq_r <= !((avsReq.read || avsReq.write) && waitReq_r);
            if (avsReq.read && waitReq_r)
                readData_r <= {24'h00_0000, rdMux};
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        case (avsReq.address)
            OFF_CTL8:    rdMux = {en8_r, single8_r, flag8_r, clk8_r, capIe8_r, toIe8_r,
                                  pinSel_r};
            OFF_SHARED:  rdMux = {1'b0, shared_r};
            OFF_CTL16:   rdMux = {en16_r, single16_r, flag16_r, clk16_r, capIe16_r,
                                  toIe16_r, 1'b0};
            OFF_HOLD8H:  rdMux = hold8H_r;
            OFF_HOLD8L:  rdMux = hold8L_r;
            OFF_HOLD16L: rdMux = hold16_r[7:0];
            OFF_HOLD16U: rdMux = hold16_r[15:8];
            OFF_CAP8:    rdMux = cap8_r;
            OFF_CAP16L:  rdMux = cap16_r[7:0];
            OFF_CAP16U:  rdMux = cap16_r[15:8];
            OFF_IRQSTAT: rdMux = {4'h0, irqStat_r};
            OFF_IRQMASK: rdMux = {4'h0, irqMask_r};
            default:     rdMux = 8'h00;
        endcase
    end

    // Configuration and hold registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shared_r  <= 7'h00;
            hold8H_r  <= RST_BYTE;
            hold8L_r  <= RST_BYTE;
            hold16_r  <= RST_WORD;
            irqMask_r <= 4'h0;
            toIe8_r   <= 1'b0;
            capIe8_r  <= 1'b0;
            clk8_r    <= 2'h0;
            toIe16_r  <= 1'b0;
            capIe16_r <= 1'b0;
            clk16_r   <= 2'h0;
        end
        else if (wr)
        begin
            case (avsReq.address)
                OFF_SHARED:  shared_r <= wd[6:0];
                OFF_HOLD8H:  hold8H_r <= wd;
                OFF_HOLD8L:  hold8L_r <= wd;
                OFF_HOLD16L: hold16_r[7:0] <= wd;
                OFF_HOLD16U: hold16_r[15:8] <= wd;
                OFF_IRQMASK: irqMask_r <= wd[3:0];
                OFF_CTL8:
                begin
                    toIe8_r  <= wd[B_TOIE];
                    capIe8_r <= wd[B_CAPIE];
                    clk8_r   <= wd[B_CLKHI:B_CLKLO];
                end
                OFF_CTL16:
                begin
                    toIe16_r  <= wd[B_TOIE];
                    capIe16_r <= wd[B_CAPIE];
                    clk16_r   <= wd[B_CLKHI:B_CLKLO];
                end
                default: ;
            endcase
        end
    end

    // Timeout flags: write one clears, a same-cycle event wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flag8_r  <= 1'b0;
            flag16_r <= 1'b0;
        end
        else
        begin
            if (term8)
                flag8_r <= 1'b1;
            else if (wrCtl8 && wd[B_FLAG])
                flag8_r <= 1'b0;
            if (to16)
                flag16_r <= 1'b1;
            else if (wrCtl16 && wd[B_FLAG])
                flag16_r <= 1'b0;
        end
    end

    // 8-bit counter; stop recovery clears only the non-retained bits
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pinSel_r  <= 1'b0;
            single8_r <= 1'b0;
            en8_r     <= 1'b0;
            out8_r    <= 1'b0;
            cnt8_r    <= RST_BYTE;
            cap8_r    <= RST_BYTE;
        end
        else if (stopRecover)
        begin
            pinSel_r  <= 1'b0;
            single8_r <= 1'b0;
            en8_r     <= 1'b0;
        end
        else if (wrCtl8)
        begin
            pinSel_r  <= wd[B_PINSEL];
            single8_r <= wd[B_SINGLE];
            en8_r     <= wd[B_EN];
            if (wd[B_EN] && !en8_r)
            begin
                out8_r <= shared_r[B_INIT8];
                cnt8_r <= shared_r[B_INIT8] ? hold8H_r : hold8L_r;
            end
        end
        else if (to16 && pingPong && !demod)
        begin
            en8_r  <= 1'b1;
            out8_r <= shared_r[B_INIT8];
            cnt8_r <= shared_r[B_INIT8] ? hold8H_r : hold8L_r;
        end
        else if (cap8Ev)
        begin
            cap8_r <= cnt8_r;
            cnt8_r <= hold8H_r;
        end
        else if (term8)
        begin
            out8_r <= !out8_r;
            // Next level decides which hold value to use
            cnt8_r <= out8_r ? hold8L_r : hold8H_r;
            if ((pingPong || single8_r) && !demod)
                en8_r <= 1'b0;
        end
        else if (en8_r && tick8)
            cnt8_r <= cnt8_r - 8'h01;
    end

    // 16-bit counter with demodulation capture and single-pass arming
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            single16_r <= 1'b0;
            en16_r     <= 1'b0;
            armed_r    <= 1'b0;
            out16_r    <= 1'b0;
            cnt16_r    <= RST_WORD;
            cap16_r    <= RST_WORD;
        end
        else
        begin
            if (cap16Ev)
                cap16_r <= cnt16_r;
            if (wrCtl16)
            begin
                single16_r <= wd[B_SINGLE];
                en16_r     <= wd[B_EN];
                // Writing the single-pass bit as 1 while it is clear or while the counter is stopped rearms one edge
                if (wd[B_SINGLE] && (!single16_r || !en16_r))
                    armed_r <= 1'b1;
                if (wd[B_EN] && !en16_r)
                begin
                    out16_r <= shared_r[B_INIT16];
                    cnt16_r <= hold16_r;
                end
            end
            else if (term8 && pingPong && !demod)
            begin
                en16_r  <= 1'b1;
                out16_r <= shared_r[B_INIT16];
                cnt16_r <= hold16_r;
            end
            else if (take16)
            begin
                cnt16_r <= hold16_r;
                armed_r <= 1'b0;
            end
            else if (to16 && !demod)
            begin
                out16_r <= !out16_r;
                if (pingPong || single16_r)
                    en16_r <= 1'b0;
                else
                    cnt16_r <= hold16_r;
            end
            else if (en16_r && tick16)
                cnt16_r <= cnt16_r - 16'h0001;
        end
    end

    // Sticky interrupt status, write-one-to-clear, set wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irqStat_r <= 4'h0;
            irq_r     <= 1'b0;
        end
        else
        begin
            if (wr && avsReq.address == OFF_IRQSTAT)
                irqStat_r <= (irqStat_r & ~wd[3:0]) | irqSet;
            else
                irqStat_r <= irqStat_r | irqSet;
            irq_r <= |(irqStat_r & irqMask_r);
        end
    end

    // Pin routing and input history
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_r       <= 1'b0;
            demodPrev_r <= 1'b0;
        end
        else
        begin
            pin_r       <= pinSel_r ? out8_r : portOutBit;
            demodPrev_r <= demodIn;
        end
    end

    assign avsReadData             = readData_r;
    assign avsWaitRequest          = waitReq_r;
    assign port3Bit4Pin            = pin_r;
    assign eightBitCounterOutput   = out8_r;
    assign sixteenBitCounterOutput = out16_r;
    assign irq                     = irq_r;

    // Checks
    property p_pin_route;
        @(posedge clk) disable iff (!rstn)
        pinSel_r |=> port3Bit4Pin == $past(out8_r);
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("pin not 8-bit out");

    property p_flag_clear;
        @(posedge clk) disable iff (!rstn)
        wrCtl8 && wd[B_FLAG] && !term8 |=> !flag8_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_pp_to16;
        @(posedge clk) disable iff (!rstn)
        term8 && pingPong && !demod && !wrCtl8 && !wrCtl16 && !stopRecover
        |=> en16_r && !en8_r && cnt16_r == hold16_r;
    endproperty
    a_pp_to16: assert property (p_pp_to16) else $error("ping-pong 8 to 16");

    property p_pp_to8;
        @(posedge clk) disable iff (!rstn)
        to16 && pingPong && !demod && !wrCtl8 && !wrCtl16 && !stopRecover
        |=> en8_r && !en16_r && out8_r == $past(shared_r[B_INIT8]);
    endproperty
    a_pp_to8: assert property (p_pp_to8) else $error("ping-pong 16 to 8");

    property p_wrap;
        @(posedge clk) disable iff (!rstn)
        to16 && demod && !wrCtl16 |=> cnt16_r == WRAP16 && flag16_r;
    endproperty
    a_wrap: assert property (p_wrap) else $error("16-bit wrap");

    property p_single_ignore;
        @(posedge clk) disable iff (!rstn)
        en16_r && demod && single16_r && !armed_r && !term8 |=> $stable(cap16_r);
    endproperty
    a_single_ignore: assert property (p_single_ignore) else $error("edge taken");

    property p_to8_capture;
        @(posedge clk) disable iff (!rstn)
        en16_r && demod && single16_r && term8 |=> cap16_r == $past(cnt16_r);
    endproperty
    a_to8_capture: assert property (p_to8_capture) else $error("no capture");

    property p_rearm;
        @(posedge clk) disable iff (!rstn)
        wrCtl16 && wd[B_SINGLE] && !single16_r |=> armed_r;
    endproperty
    a_rearm: assert property (p_rearm) else $error("not rearmed");

    property p_start8;
        @(posedge clk) disable iff (!rstn)
        wrCtl8 && wd[B_EN] && !en8_r && !stopRecover
        |=> en8_r && out8_r == $past(shared_r[B_INIT8]);
    endproperty
    a_start8: assert property (p_start8) else $error("start level");

    property p_toie_gate;
        @(posedge clk) disable iff (!rstn)
        term8 && !toIe8_r && !irqStat_r[IRQ_TO8] |=> !irqStat_r[IRQ_TO8];
    endproperty
    a_toie_gate: assert property (p_toie_gate) else $error("ungated irq");

    property p_bus_answer;
        @(posedge clk) disable iff (!rstn)
        (avsReq.read || avsReq.write) && waitReq_r |=> !waitReq_r ##1 waitReq_r;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_pingpong: cover property (@(posedge clk) disable iff (!rstn)
        term8 && pingPong ##[1:1000] to16 && pingPong);
    c_rearm: cover property (@(posedge clk) disable iff (!rstn)
        armed_r ##[1:100] take16);
    c_irq: cover property (@(posedge clk) disable iff (!rstn) irq_r);

endmodule : irtp_timer_pair

// ### core/irtp_pkg.sv
/*
 * Package for the IR timer pair: register offsets, field positions,
 * reset values, mode codes and the Avalon-MM request carrier.
 * Assumes a 32-bit Avalon-MM slave port with byte addressing.
 */
package irtp_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTL8    = 8'h00;
    localparam logic [7:0] OFF_SHARED  = 8'h04;
    localparam logic [7:0] OFF_CTL16   = 8'h08;
    localparam logic [7:0] OFF_HOLD8H  = 8'h0C;
    localparam logic [7:0] OFF_HOLD8L  = 8'h10;
    localparam logic [7:0] OFF_HOLD16L = 8'h14;
    localparam logic [7:0] OFF_HOLD16U = 8'h18;
    localparam logic [7:0] OFF_CAP8    = 8'h1C;
    localparam logic [7:0] OFF_CAP16L  = 8'h20;
    localparam logic [7:0] OFF_CAP16U  = 8'h24;
    localparam logic [7:0] OFF_IRQSTAT = 8'h28;
    localparam logic [7:0] OFF_IRQMASK = 8'h2C;

    // Control field positions, shared by both counter control registers except B_PINSEL, which only the 8-bit one has
    localparam int B_PINSEL = 0;
    localparam int B_TOIE   = 1;
    localparam int B_CAPIE  = 2;
    localparam int B_CLKLO  = 3;
    localparam int B_CLKHI  = 4;
    localparam int B_FLAG   = 5;
    localparam int B_SINGLE = 6;
    localparam int B_EN     = 7;

    // Shared control field positions
    localparam int B_INIT16 = 0;
    localparam int B_INIT8  = 1;
    localparam int B_MODELO = 2;
    localparam int B_MODEHI = 3;
    localparam int B_EDGELO = 4;
    localparam int B_EDGEHI = 5;
    localparam int B_DEMOD  = 6;

    // Mode and edge codes
    localparam logic [1:0] MODE_PINGPONG = 2'h1;
    localparam logic [1:0] EDGE_RISE     = 2'h1;
    localparam logic [1:0] EDGE_FALL     = 2'h2;
    localparam logic [1:0] EDGE_BOTH     = 2'h3;

    // Interrupt status bit positions
    localparam int IRQ_TO8  = 0;
    localparam int IRQ_CAP8 = 1;
    localparam int IRQ_TO16 = 2;
    localparam int IRQ_CAP16 = 3;

    // Reset values and the 16-bit wrap value
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [15:0] WRAP16    = 16'hFFFF;

    // Avalon-MM request carrier
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } irtp_avs_req_t;

endpackage : irtp_pkg

// ### tb/irtp_pulse_src.sv
/*
 * Far-side model: the pulse source on the demodulation input.
 * Assumes clk and rst_n come from the bench.
 */
`timescale 1ns/100ps
module irtp_pulse_src (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [7:0] halfLen,
    // Line to the block
    output logic            demodIn
);
    logic [7:0] cnt_r;

    // Square wave while running; idle low so no stray edge appears
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r   <= 8'h00;
            demodIn <= 1'b0;
        end
        else if (!run)
        begin
            cnt_r   <= 8'h00;
            demodIn <= 1'b0;
        end
        else if (cnt_r >= halfLen)
        begin
            cnt_r   <= 8'h00;
            demodIn <= ~demodIn;
        end
        else
            cnt_r <= cnt_r + 8'h01;
    end
endmodule : irtp_pulse_src

// ### tb/irtp_timer_pair_tb.sv
/*
 * Bench for the IR timer pair: Avalon tasks, a queue of expected reads,
 * a pulse source. Assumes a one-cycle bus answer and 2-flop reset.
 */
`timescale 1ns/100ps
module irtp_timer_pair_tb;
    import irtp_pkg::*;
    logic          clk, rst_n, portOutBit, stopRecover, pulseRun, demodIn;
    logic          port3Bit4Pin, eightBitCounterOutput, sixteenBitCounterOutput, irq;
    irtp_avs_req_t avsReq;
    logic [31:0]   avsReadData;
    logic          avsWaitRequest;
    logic [7:0]    pulseLen, rdq, capA;
    logic [15:0]   noteQ[$];
    logic [15:0]   note;
    int            errors, compares, i;

    irtp_timer_pair dut (.clk(clk), .rst_n(rst_n), .avsReq(avsReq),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .portOutBit(portOutBit), .demodIn(demodIn), .stopRecover(stopRecover),
        .port3Bit4Pin(port3Bit4Pin), .eightBitCounterOutput(eightBitCounterOutput),
        .sixteenBitCounterOutput(sixteenBitCounterOutput), .irq(irq));
    irtp_pulse_src src (.clk(clk), .rst_n(rst_n), .run(pulseRun),
        .halfLen(pulseLen), .demodIn(demodIn));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Automatic: the read checker and the main sequence both call it
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            errors++;
    endtask : cmp

    // Holds the request until waitrequest is seen low, then one idle edge
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        avsReq <= '{!wr, wr, a, 4'hF, {24'h000000, d}};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avsWaitRequest !== 1'b0 && n < 40);
        if (n >= 40)
            errors++;
        rdq = avsReadData[7:0];
        avsReq <= '0;
        @(posedge clk);
    endtask : bus

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    // Note {mask, value}; a zero mask means the read is not judged
    task rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        noteQ.push_back({m, v});
        bus(1'b0, a, 8'h00);
    endtask : rd

    task poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        int n;
        n = 0;
        do
        begin
            rd(a, 8'h00, 8'h00);
            n++;
        end
        while ((rdq & m) !== v && n < 200);
        cmp(rdq & m, v);
    endtask : poll

    task waitc(input int n);
        repeat (n) @(posedge clk);
    endtask : waitc

    task close_out;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // Oldest note is judged at the edge where read data stand
    always @(posedge clk)
    begin
        if (avsReq.read && avsWaitRequest === 1'b0 && noteQ.size() > 0)
        begin
            note = noteQ.pop_front();
            if (note[15:8] != 8'h00)
                cmp(avsReadData[7:0] & note[15:8], note[7:0]);
        end
    end

    // Watchdog, far beyond the few thousand cycles the tests need
    initial
    begin
        #200000;
        errors++;
        close_out;
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'h8801E8D5));
        {portOutBit, stopRecover, pulseRun, errors, compares} = '0;
        avsReq = '0;
        rst_n = 1'b0;
        pulseLen = 8'h10 + 8'($urandom_range(7));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        waitc(4);
        rd(OFF_CTL8, RST_BYTE, 8'hFF);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00, 8'hFF);
        for (i = 0; i < 8; i++)
        begin
            portOutBit <= 1'($urandom);
            waitc(3);
            cmp({7'h00, port3Bit4Pin}, {7'h00, portOutBit});
        end
        wr(OFF_CTL8, 8'h01);
        portOutBit <= ~eightBitCounterOutput;
        waitc(3);
        cmp({7'h00, port3Bit4Pin}, {7'h00, eightBitCounterOutput});
        // Each clock divide: flag must be clear early and set late
        wr(OFF_HOLD8L, 8'h07);
        wr(OFF_IRQMASK, 8'h01);
        for (i = 0; i < 4; i++)
        begin
            wr(OFF_CTL8, {2'b11, 1'b0, 2'(i), 3'b010});
            waitc(3 << i);
            rd(OFF_CTL8, 8'h00, 8'h20);
            waitc(9 << i);
            rd(OFF_CTL8, 8'h20, 8'h20);
            cmp({7'h00, irq}, 8'h01);
            wr(OFF_CTL8, 8'h00);
            rd(OFF_CTL8, 8'h20, 8'hA0);
            wr(OFF_CTL8, 8'h20);
            wr(OFF_IRQSTAT, 8'h0F);
            rd(OFF_CTL8, 8'h00, 8'h20);
            cmp({7'h00, irq}, 8'h00);
        end
        wr(OFF_CTL8, 8'hC0);
        waitc(20);
        rd(OFF_IRQSTAT, 8'h00, 8'h01);
        wr(OFF_CTL8, 8'hDF);
        stopRecover <= 1'b1;
        @(posedge clk);
        stopRecover <= 1'b0;
        @(posedge clk);
        rd(OFF_CTL8, 8'h3E, 8'hFF);
        wr(OFF_CTL8, 8'h20);
        wr(OFF_IRQSTAT, 8'h0F);
        // Ping-pong from stopped counters with clean flags
        wr(OFF_HOLD8H, 8'h04);
        wr(OFF_HOLD16L, 8'h10);
        wr(OFF_HOLD16U, 8'h00);
        wr(OFF_CTL16, 8'h40);
        wr(OFF_SHARED, 8'h07);
        wr(OFF_CTL8, 8'hC3);
        waitc(1);
        cmp({7'h00, eightBitCounterOutput}, 8'h01);
        poll(OFF_CTL8, 8'h80, 8'h00);
        cmp({7'h00, sixteenBitCounterOutput}, 8'h01);
        poll(OFF_CTL8, 8'h80, 8'h80);
        rd(OFF_IRQSTAT, 8'h01, 8'h05);
        wr(OFF_SHARED, 8'h00);
        waitc(200);
        rd(OFF_CTL8, 8'h00, 8'h80);
        rd(OFF_CTL16, 8'h00, 8'h80);
        wr(OFF_CTL8, 8'h20);
        wr(OFF_CTL16, 8'h20);
        wr(OFF_IRQSTAT, 8'h0F);
        // Demodulation capture, single pass, rising edges
        wr(OFF_HOLD16U, 8'h01);
        wr(OFF_SHARED, 8'h50);
        wr(OFF_CTL16, 8'hC6);
        pulseRun <= 1'b1;
        waitc(60);
        rd(OFF_CAP16L, 8'h00, 8'h00);
        capA = rdq;
        waitc(100);
        rd(OFF_CAP16L, capA, 8'hFF);
        pulseRun <= 1'b0;
        // Drop the edge-capture interrupt so only the timeout capture can set it
        wr(OFF_IRQSTAT, 8'h08);
        wr(OFF_CTL8, 8'hC0);
        waitc(20);
        rd(OFF_CAP16L, 8'h00, 8'h00);
        cmp({7'h00, rdq !== capA}, 8'h01);
        rd(OFF_IRQSTAT, 8'h08, 8'h08);
        waitc(300);
        rd(OFF_CTL16, 8'hA0, 8'hA0);
        rd(OFF_IRQSTAT, 8'h04, 8'h04);
        // Stop the 8-bit so its timeouts cannot capture during the rearm check
        wr(OFF_CTL8, 8'h20);
        wr(OFF_CTL16, 8'h86);
        wr(OFF_CTL16, 8'hC6);
        rd(OFF_CAP16L, 8'h00, 8'h00);
        capA = rdq;
        pulseRun <= 1'b1;
        waitc(60);
        rd(OFF_CAP16L, 8'h00, 8'h00);
        cmp({7'h00, rdq !== capA}, 8'h01);
        capA = rdq;
        waitc(100);
        rd(OFF_CAP16L, capA, 8'hFF);
        // 8-bit capture interrupt on a rising input edge
        wr(OFF_IRQSTAT, 8'h0F);
        wr(OFF_CTL8, 8'hC4);
        waitc(60);
        rd(OFF_IRQSTAT, 8'h02, 8'h02);
        close_out;
    end
endmodule : irtp_timer_pair_tb
